// ### rtl/rsb_pkg.sv
package rsb_pkg;
  // host port strap codes
  localparam logic [1:0] HP_I2C_A0  = 2'h0;
  localparam logic [1:0] HP_I2C_A1  = 2'h1;
  localparam logic [1:0] HP_SPI_SLV = 2'h2;
  localparam logic [1:0] HP_SPI_MST = 2'h3;
  // default i2c slave addresses
  localparam logic [6:0] I2C_ADDR_A0 = 7'h74;
  localparam logic [6:0] I2C_ADDR_A1 = 7'h75;
  // boot config codes with test strap high
  localparam logic [2:0] TST_PROG_INT = 3'h0;
  localparam logic [2:0] TST_NO_BOOT  = 3'h3;
  // strap capture status layout: {test, boot_config_select[2:0], host_mode[1:0]}
  localparam int         STS_W         = 6;
  localparam logic [5:0] STS_RST       = 6'h00;
  // identity values, arbitrary
  localparam logic [11:0] ID_VALUE  = 12'h5a3;
  localparam logic [3:0]  REV_VALUE = 4'h1;
  // spi master boot frame: 8 command bits, 16 address bits, read data
  localparam logic [7:0] EE_READ_CMD = 8'h03;
  localparam int         EE_HDR_BITS = 24;
  localparam logic [7:0] EE_DATA_BITS = 8'h08;
  localparam logic [7:0] EE_FRAME_BITS = 8'h20;
  localparam logic [7:0] SCLK_HALF  = 8'h02;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_DEC  = 5'b00010,
    ST_BOOT = 5'b00100,
    ST_SPI  = 5'b01000,
    ST_DONE = 5'b10000
  } rsb_state_t;
endpackage

// ### rtl/rsb_shift.sv
`timescale 1ns/100ps
module rsb_shift
  import rsb_pkg::*;
(
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  // control
  input  wire logic        load_i,
  input  wire logic [31:0] load_data_i,
  input  wire logic        shift_i,
  input  wire logic        sin_i,
  // data
  output logic             sout_o,
  output logic [31:0]      word_o
);
  typedef struct packed {
    logic [31:0] sr;
  } rsb_shift_st_t;

  rsb_shift_st_t cur_ff;
  rsb_shift_st_t nxt_st;

  // shift out msb, shift in at lsb
  always_comb begin
    nxt_st = cur_ff;
    if (load_i) begin
      nxt_st.sr = load_data_i;
    end else if (shift_i) begin
      nxt_st.sr = {cur_ff.sr[30:0], sin_i};
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_st;
    end
  end

  assign sout_o = cur_ff.sr[31];
  assign word_o = cur_ff.sr;
endmodule

// ### rtl/rsb_top.sv
// Overview of operation
// R01 - sample straps at reset release, latch status
// R02 - after reset pins take run-time roles
// R03 - test strap high enters test mode
// R04 - test with boot 011 skips auto-configuration
// R05 - test, 000, 11 enables internal memory programming
// R06 - host 00: i2c address 1110100, rom
// R07 - host 01: i2c address 1110101, rom
// R08 - host 10: spi slave, rom boot
// R09 - host 11: spi master eeprom, then slave
// R10 - boot straps select configuration zero to seven
// R11 - i2c address register overrides strap default
// R12 - read-only 12-bit id, 4-bit revision
// R13 - spi master drives command, address, data out
// R14 - host drives master-out in slave mode
// R15 - eeprom select follows device select at boot
// R16 - i2c data line bidirectional, shared drive
// R17 - chip select becomes input after boot
// R18 - boot done flag set when configuration completes
// R19 - strap status held until next reset
`timescale 1ns/100ps
module rsb_top
  import rsb_pkg::*;
(
  // clock and reset
  input  wire logic              mclk_i,
  input  wire logic              rst_n_i,
  // strap pins, sampled at reset release
  input  wire logic              test_strap_i,
  input  wire logic [2:0]        boot_config_select_i,
  input  wire logic [1:0]        host_strap_i,
  // i2c address register write
  input  wire logic              i2c_addr_wr_i,
  input  wire logic [6:0]        i2c_addr_wdata_i,
  // i2c data drive request from slave engine
  input  wire logic              i2c_sda_drive_low_i,
  // spi pins
  input  wire logic              spi_miso_i,
  output logic                   spi_sclk_o,
  output logic                   spi_sclk_oe_o,
  output logic                   spi_mosi_o,
  output logic                   spi_mosi_oe_o,
  output logic                   spi_chip_select_n_o,
  output logic                   spi_chip_select_n_oe_o,
  // i2c data pin
  output logic                   i2c_sda_o,
  output logic                   i2c_sda_oe_o,
  // boot script interface
  output logic                   boot_word_valid_o,
  output logic [7:0]             boot_word_o,
  input  wire logic              boot_script_end_i,
  // status
  output logic [STS_W-1:0]       strap_capture_status_o,
  output logic                   test_mode_o,
  output logic                   skip_autocfg_o,
  output logic                   int_mem_prog_o,
  output logic [2:0]             config_index_o,
  output logic                   boot_from_eeprom_o,
  output logic                   host_i2c_o,
  output logic                   host_spi_slave_o,
  output logic                   general_pins_run_o,
  output logic [6:0]             i2c_slave_addr_reg_o,
  output logic [11:0]            identity_reg_high_o,
  output logic [3:0]             identity_reg_low_o,
  output logic                   boot_done_flag_o
);
  typedef struct packed {
    rsb_state_t       st;
    logic             captured;
    logic [STS_W-1:0] sts;
    logic [6:0]       addr;
    logic             done;
    logic             run;
    logic [7:0]       half_cnt;
    logic [7:0]       bit_cnt;
    logic             sclk;
    logic             cs_n;
    logic             cs_oe;
    logic             drv;
    logic             wvalid;
    logic [15:0]      ee_addr;
    logic             sda_oe;
    logic             tst;
    logic             skip;
    logic             prog;
    logic             ee;
    logic             i2c;
    logic             spis;
  } rsb_st_t;

  rsb_st_t     cur_ff;
  rsb_st_t     nxt_st;
  logic        sh_load;
  logic        sh_shift;
  logic        sh_out;
  logic [31:0] sh_word;
  logic        t_s;
  logic [2:0]  ac_s;
  logic [1:0]  hp_s;

  assign t_s  = cur_ff.sts[5];
  assign ac_s = cur_ff.sts[4:2];
  assign hp_s = cur_ff.sts[1:0];

  rsb_shift u_shift (
    .mclk_i      (mclk_i),
    .rst_n_i     (rst_n_i),
    .load_i      (sh_load),
    .load_data_i ({EE_READ_CMD, cur_ff.ee_addr, 8'h00}),
    .shift_i     (sh_shift),
    .sin_i       (spi_miso_i),
    .sout_o      (sh_out),
    .word_o      (sh_word)
  );

  always_comb begin
    nxt_st   = cur_ff;
    sh_load  = 1'b0;
    sh_shift = 1'b0;
    nxt_st.wvalid = 1'b0;
    // i2c data line: open drain, engine pulls low during its phases
    nxt_st.sda_oe = i2c_sda_drive_low_i && (hp_s == HP_I2C_A0 || hp_s == HP_I2C_A1) && cur_ff.run; // R16
    if (cur_ff.run && i2c_addr_wr_i) begin
      nxt_st.addr = i2c_addr_wdata_i; // R11
    end
    unique case (cur_ff.st)
      ST_IDLE: begin
        // first clock after reset release catches the straps once
        nxt_st.sts      = {test_strap_i, boot_config_select_i, host_strap_i}; // R01
        nxt_st.captured = 1'b1; // R19
        // first frame address must be ready when decode loads the shifter
        nxt_st.ee_addr  = {5'h00, boot_config_select_i, 8'h00}; // R10
        nxt_st.st       = ST_DEC;
      end
      ST_DEC: begin
        nxt_st.run = 1'b1; // R02
        // defaults only on the first pass, so a host write survives later frames
        if (!cur_ff.run) begin
          unique case (hp_s)
            HP_I2C_A0: nxt_st.addr = I2C_ADDR_A0; // R06
            HP_I2C_A1: nxt_st.addr = I2C_ADDR_A1; // R07
            default:   nxt_st.addr = I2C_ADDR_A0;
          endcase
        end
        if (t_s && (ac_s == TST_NO_BOOT || (ac_s == TST_PROG_INT && hp_s == HP_SPI_MST))) begin
          nxt_st.st   = ST_DONE; // R04 R05
          nxt_st.done = 1'b1;
        end else if (hp_s == HP_SPI_MST) begin
          nxt_st.st    = ST_SPI; // R09
          nxt_st.cs_oe = 1'b1;
          nxt_st.cs_n  = 1'b0;
          nxt_st.drv   = 1'b1;
          sh_load      = 1'b1;
        end else begin
          nxt_st.st = ST_BOOT; // R08
        end
      end
      ST_BOOT: begin
        if (boot_script_end_i) begin
          nxt_st.st   = ST_DONE;
          nxt_st.done = 1'b1; // R18
        end
      end
      ST_SPI: begin
        // mode 0 read: mosi out and miso captured on falling edge, eeprom samples mosi on rising edge
        nxt_st.half_cnt = cur_ff.half_cnt + 8'h01;
        if (cur_ff.half_cnt == SCLK_HALF - 8'h01) begin
          nxt_st.half_cnt = 8'h00;
          nxt_st.sclk     = ~cur_ff.sclk;
          if (cur_ff.sclk) begin
            sh_shift       = 1'b1; // R13
            nxt_st.bit_cnt = cur_ff.bit_cnt + 8'h01;
            if (cur_ff.bit_cnt == EE_FRAME_BITS - 8'h01) begin
              nxt_st.wvalid  = 1'b1;
              nxt_st.bit_cnt = 8'h00;
              nxt_st.cs_n    = 1'b1;
              if (boot_script_end_i) begin
                nxt_st.st    = ST_DONE;
                nxt_st.done  = 1'b1;
                nxt_st.drv   = 1'b0;
                nxt_st.cs_oe = 1'b0; // R17
              end else begin
                nxt_st.ee_addr = cur_ff.ee_addr + 16'h0001;
                nxt_st.st      = ST_DEC;
              end
            end
          end
        end
      end
      ST_DONE: begin
        nxt_st.done = 1'b1;
      end
      default: nxt_st.st = ST_IDLE;
    endcase
    // decodes taken from the next state so every decoded output leaves a flop
    nxt_st.tst  = nxt_st.run & nxt_st.sts[5]; // R03
    nxt_st.skip = nxt_st.tst & (nxt_st.sts[4:2] == TST_NO_BOOT); // R04
    nxt_st.prog = nxt_st.tst & (nxt_st.sts[4:2] == TST_PROG_INT) & (nxt_st.sts[1:0] == HP_SPI_MST); // R05
    nxt_st.ee   = nxt_st.run & (nxt_st.sts[1:0] == HP_SPI_MST) & ~nxt_st.skip & ~nxt_st.prog; // R09
    nxt_st.i2c  = nxt_st.run & ~nxt_st.sts[1]; // R06
    nxt_st.spis = nxt_st.run & nxt_st.sts[1] & (~nxt_st.sts[0] | nxt_st.done); // R08
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cur_ff      <= '0;
      cur_ff.st   <= ST_IDLE;
      cur_ff.sts  <= STS_RST;
      cur_ff.cs_n <= 1'b1;
    end else begin
      cur_ff <= nxt_st;
    end
  end

  // decoded outputs from registered state; identity values and the i2c data level are constants
  assign strap_capture_status_o = cur_ff.sts; // R19
  assign test_mode_o            = cur_ff.tst; // R03
  assign skip_autocfg_o         = cur_ff.skip; // R04
  assign int_mem_prog_o         = cur_ff.prog; // R05
  assign config_index_o         = ac_s; // R10
  assign boot_from_eeprom_o     = cur_ff.ee; // R09
  assign host_i2c_o             = cur_ff.i2c; // R06
  assign host_spi_slave_o       = cur_ff.spis; // R08
  assign general_pins_run_o     = cur_ff.run; // R02
  assign i2c_slave_addr_reg_o   = cur_ff.addr;
  assign identity_reg_high_o    = ID_VALUE; // R12
  assign identity_reg_low_o     = REV_VALUE; // R12
  assign boot_done_flag_o       = cur_ff.done; // R18
  assign spi_sclk_o             = cur_ff.sclk;
  assign spi_sclk_oe_o          = cur_ff.drv;
  assign spi_mosi_o             = sh_out; // R13
  assign spi_mosi_oe_o          = cur_ff.drv; // R13
  assign spi_chip_select_n_o    = cur_ff.cs_n;
  assign spi_chip_select_n_oe_o = cur_ff.cs_oe; // R17
  assign i2c_sda_o              = 1'b0;
  assign i2c_sda_oe_o           = cur_ff.sda_oe;
  assign boot_word_valid_o      = cur_ff.wvalid;
  assign boot_word_o            = sh_word[7:0];
endmodule

// ### verification/rsb_top_properties.sv
`timescale 1ns/100ps
module rsb_top_properties
  import rsb_pkg::*;
(
  input wire logic             mclk_i,
  input wire logic             rst_n_i,
  input wire logic             i2c_addr_wr_i,
  input wire logic [6:0]       i2c_addr_wdata_i,
  input wire logic             boot_script_end_i,
  input wire logic [STS_W-1:0] strap_capture_status_o,
  input wire logic             test_mode_o,
  input wire logic [2:0]       config_index_o,
  input wire logic             boot_from_eeprom_o,
  input wire logic             general_pins_run_o,
  input wire logic [6:0]       i2c_slave_addr_reg_o,
  input wire logic [11:0]      identity_reg_high_o,
  input wire logic [3:0]       identity_reg_low_o,
  input wire logic             boot_done_flag_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_run;
    general_pins_run_o;
  endsequence
  sequence s_rom_end;
    general_pins_run_o && !boot_from_eeprom_o && !boot_done_flag_o && boot_script_end_i;
  endsequence
  property p_hold;
    s_run ##1 general_pins_run_o |-> $stable(strap_capture_status_o);
  endproperty
  property p_test;
    s_run |-> test_mode_o == strap_capture_status_o[5];
  endproperty
  property p_cfg;
    s_run |-> config_index_o == strap_capture_status_o[4:2];
  endproperty
  property p_def;
    $rose(general_pins_run_o) |->
      i2c_slave_addr_reg_o == (strap_capture_status_o[1:0] == HP_I2C_A1 ? I2C_ADDR_A1 : I2C_ADDR_A0);
  endproperty
  property p_wr;
    general_pins_run_o && i2c_addr_wr_i |=> i2c_slave_addr_reg_o == $past(i2c_addr_wdata_i);
  endproperty
  property p_id;
    s_run |-> identity_reg_high_o == ID_VALUE && identity_reg_low_o == REV_VALUE;
  endproperty
  property p_done;
    boot_done_flag_o |=> boot_done_flag_o;
  endproperty
  property p_rom;
    s_rom_end |-> ##[1:2] boot_done_flag_o;
  endproperty
  a_hold: assert property (p_hold) else $error("strap status changed");
  a_test: assert property (p_test) else $error("test mode decode wrong");
  a_cfg: assert property (p_cfg) else $error("config index wrong");
  a_def: assert property (p_def) else $error("default address wrong");
  a_wr: assert property (p_wr) else $error("address write lost");
  a_id: assert property (p_id) else $error("identity value wrong");
  a_done: assert property (p_done) else $error("boot done dropped");
  a_rom: assert property (p_rom) else $error("rom boot not done");
endmodule
bind rsb_top rsb_top_properties u_props (.mclk_i, .rst_n_i, .i2c_addr_wr_i, .i2c_addr_wdata_i,
  .boot_script_end_i, .strap_capture_status_o, .test_mode_o, .config_index_o, .boot_from_eeprom_o,
  .general_pins_run_o, .i2c_slave_addr_reg_o, .identity_reg_high_o, .identity_reg_low_o, .boot_done_flag_o);

// ### verification/rsb_eeprom_model.sv
`timescale 1ns/100ps
module rsb_eeprom_model (
  input  wire logic   sclk_i,
  input  wire logic   cs_n_i,
  input  wire logic   mosi_i,
  output logic        miso_o = 1'b1,
  output logic [23:0] hdr_o = 24'h0
);
  logic [5:0] cnt = 6'h0;
  logic [7:0] dat;
  assign dat = hdr_o[7:0] ^ 8'h3c;
  always @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i)
      cnt <= 6'h0;
    else begin
      if (cnt < 6'd24)
        hdr_o <= {hdr_o[22:0], mosi_i};
      cnt <= cnt + 6'h1;
    end
  end
  // released line reads high through its pull-up
  always @(negedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i)
      miso_o <= 1'b1;
    else if (cnt >= 6'd24 && cnt < 6'd32)
      miso_o <= dat[~cnt[2:0]];
    else
      miso_o <= ~miso_o;
  end
endmodule

// ### verification/rsb_top_tb_top.sv
`timescale 1ns/100ps
module rsb_top_tb_top
  import rsb_pkg::*;
;
  logic mclk_i, rst_n_i = 0, test_strap_i = 0, i2c_addr_wr_i = 0, i2c_sda_drive_low_i = 0, boot_script_end_i = 0;
  logic [2:0] boot_config_select_i = 0, config_index_o;
  logic [1:0] host_strap_i = 0;
  logic [6:0] i2c_addr_wdata_i = 0, i2c_slave_addr_reg_o;
  logic spi_miso_i, spi_sclk_o, spi_sclk_oe_o, spi_mosi_o, spi_mosi_oe_o, spi_chip_select_n_o;
  logic spi_chip_select_n_oe_o, i2c_sda_o, i2c_sda_oe_o, boot_word_valid_o, test_mode_o, skip_autocfg_o;
  logic int_mem_prog_o, boot_from_eeprom_o, host_i2c_o, host_spi_slave_o, general_pins_run_o, boot_done_flag_o;
  logic [7:0] boot_word_o;
  logic [5:0] strap_capture_status_o;
  logic [11:0] identity_reg_high_o;
  logic [3:0] identity_reg_low_o;
  logic [23:0] hdr;
  int num_errors = 0;
  int samples_checked = 0;
  localparam logic [5:0] CRN [6] = '{6'h2c, 6'h23, 6'h1f, 6'h00, 6'h15, 6'h0a};
  rsb_top u_dut (.*);
  rsb_eeprom_model u_ee (
    .sclk_i (spi_sclk_o),
    .cs_n_i (spi_chip_select_n_oe_o ? spi_chip_select_n_o : 1'b1),
    .mosi_i (spi_mosi_o),
    .miso_o (spi_miso_i),
    .hdr_o  (hdr)
  );
  initial begin
    mclk_i = 0;
    forever #12.5 mclk_i = ~mclk_i;
  end
  task automatic step;
    @(posedge mclk_i);
    #1;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic summarize;
    $display("checked %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic boot_one(input logic [5:0] v);
    logic t;
    logic [2:0] ac;
    logic [1:0] h;
    logic ee;
    logic [6:0] w;
    int k;
    {t, ac, h} = v;
    ee = h == 2'h3 && !(t && (ac == 3'h3 || ac == 3'h0));
    rst_n_i = 0;
    {test_strap_i, boot_config_select_i, host_strap_i} = v;
    boot_script_end_i = 0;
    repeat (10) step();
    rst_n_i = 1;
    repeat (3) step();
    {test_strap_i, boot_config_select_i, host_strap_i} = ~v;
    chk("status", v, strap_capture_status_o);
    chk("run", 1, general_pins_run_o);
    chk("test", t, test_mode_o);
    chk("skip", t && ac == 3'h3, skip_autocfg_o);
    chk("prog", t && ac == 3'h0 && h == 2'h3, int_mem_prog_o);
    chk("i2c", h < 2'h2, host_i2c_o);
    chk("addr", h == 2'h1 ? I2C_ADDR_A1 : I2C_ADDR_A0, i2c_slave_addr_reg_o);
    if (h == 2'h2)
      chk("spi_slave", 1, host_spi_slave_o);
    chk("eeprom", ee, boot_from_eeprom_o);
    chk("cfg", ac, config_index_o);
    chk("id", {ID_VALUE, REV_VALUE}, {identity_reg_high_o, identity_reg_low_o});
    if (ee) begin
      for (int f = 0; f < 2; f++) begin
        k = 0;
        do begin
          step();
          k++;
        end while (boot_word_valid_o !== 1'b1 && k < 300);
        chk("word_valid", 1, boot_word_valid_o);
        chk("word", 8'(f) ^ 8'h3c, boot_word_o);
        chk("header", {EE_READ_CMD, 5'h0, ac, 8'(f)}, hdr);
        if (f == 0)
          repeat (20) step();
        boot_script_end_i = 1;
      end
    end else
      boot_script_end_i = 1;
    k = 0;
    do begin
      step();
      k++;
    end while (boot_done_flag_o !== 1'b1 && k < 300);
    step();
    chk("done", 1, boot_done_flag_o);
    chk("cs_oe", 0, spi_chip_select_n_oe_o);
    chk("mosi_oe", 0, spi_mosi_oe_o);
    chk("spi_slave_end", h[1], host_spi_slave_o);
    w = 7'($urandom());
    i2c_addr_wr_i = 1;
    i2c_addr_wdata_i = w;
    step();
    i2c_addr_wr_i = 0;
    chk("addr_wr", w, i2c_slave_addr_reg_o);
    i2c_sda_drive_low_i = 1;
    step();
    chk("sda_oe", h < 2'h2, i2c_sda_oe_o);
    chk("sda", 0, i2c_sda_o);
    i2c_sda_drive_low_i = 0;
    chk("hold", v, strap_capture_status_o);
  endtask
  initial begin
    void'($urandom(76703));
    for (int i = 0; i < 30; i++)
      boot_one(i < 6 ? CRN[i] : 6'($urandom()));
    summarize();
  end
  initial begin
    #(25 * 50000);
    num_errors++;
    summarize();
  end
endmodule
